/* File: trigger_event_report_filter.sv */
// trigger event report filter: masks sixteen trigger events, passes system events
// assumes trigger pulses from same-clock logic, manual and external pins asynchronous,
// and a downstream event store that accepts one report per cycle
`timescale 1ns/100ps
`default_nettype none
// How it works
// RULE_01: each trigger event individually enabled or suppressed
// RULE_02: event n maps to mask bit n minus one
// RULE_03: one includes event, zero excludes it
// RULE_04: mask accepts every sixteen bit value
// RULE_05: mask resets to all ones
// RULE_06: communicator makes link events, never masked here
// RULE_07: events one to five are analog limits
// RULE_08: events six to thirteen are binary changes
// RULE_09: event fourteen is manual or external trigger
// RULE_10: event fifteen is remote command trigger
// RULE_11: event sixteen is periodic trigger
// RULE_12: reset and overflow status always reported
// RULE_13: each report carries code and time stamp
// RULE_14: new mask governs only later events
module trigger_event_report_filter (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic mask_wr,
  input wire logic [15:0] mask_wdata,
  output logic [15:0] event_report_mask,
  input wire logic trig_overcurrent,
  input wire logic trig_residual_volt,
  input wire logic trig_neutral_curr,
  input wire logic trig_overvoltage,
  input wire logic trig_undervoltage,
  input wire logic [7:0] trig_binary_change,
  input wire logic manual_trigger_pin,
  input wire logic external_trigger_pin,
  input wire logic remote_trigger_command,
  input wire logic periodic_trigger,
  input wire logic unack_reset,
  input wire logic event_overflow,
  input wire logic [31:0] time_now,
  output logic report_valid,
  output logic [4:0] report_code,
  output logic [31:0] report_time,
  output logic [15:0] pending
);
  logic manual_level;
  logic external_level;
  logic manual_prev;
  logic external_prev;
  logic [15:0] raw_events;
  logic [15:0] next_pending;
  logic [15:0] masked;
  logic unack_pend;
  logic ovf_pend;
  logic [4:0] next_code;
  logic next_valid;
  logic [15:0] served;
  logic serve_unack;
  logic serve_ovf;
  logic manual_rise;
  logic external_rise;
  logic [15:0] refill;
  logic [31:0] stamp [event_filter_pkg::num_events];
  logic [31:0] unack_stamp;
  logic [31:0] ovf_stamp;
  logic [31:0] next_time;
  logic next_unack;
  logic next_ovf;

  pin_sync u_sync_manual (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin(manual_trigger_pin),
    .level(manual_level)
  );

  pin_sync u_sync_external (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin(external_trigger_pin),
    .level(external_level)
  );

  // rising edges only; idle-low pins give no false edge after reset
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      manual_prev <= 1'b0;
    end else begin
      manual_prev <= manual_level;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      external_prev <= 1'b0;
    end else begin
      external_prev <= external_level;
    end
  end

  assign manual_rise = manual_level & ~manual_prev;
  assign external_rise = external_level & ~external_prev;

  always_comb begin
    raw_events = 16'h0000;
    raw_events[event_filter_pkg::pos_overcurrent] = trig_overcurrent; // see RULE_07
    raw_events[event_filter_pkg::pos_residual_volt] = trig_residual_volt;
    raw_events[event_filter_pkg::pos_neutral_curr] = trig_neutral_curr;
    raw_events[event_filter_pkg::pos_overvoltage] = trig_overvoltage;
    raw_events[event_filter_pkg::pos_undervoltage] = trig_undervoltage;
    raw_events[event_filter_pkg::pos_binary_first +: 8] = trig_binary_change; // see RULE_08
    raw_events[event_filter_pkg::pos_manual_ext] = manual_rise | external_rise; // see RULE_09
    raw_events[event_filter_pkg::pos_remote] = remote_trigger_command; // see RULE_10
    raw_events[event_filter_pkg::pos_periodic] = periodic_trigger; // see RULE_11
  end

  // mask applied at detection, so queued events keep their status
  assign masked = raw_events & event_report_mask; // see RULE_01 see RULE_02 see RULE_03 see RULE_14

  // slot takes a fresh stamp when it opens: empty, or emptied this cycle;
  // a repeat while waiting keeps the first time of occurrence
  assign refill = masked & (~pending | served);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int i = 0; i < event_filter_pkg::num_events; i++) begin
        stamp[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < event_filter_pkg::num_events; i++) begin
        if (refill[i]) begin
          stamp[i] <= time_now; // see RULE_13
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      event_report_mask <= event_filter_pkg::mask_reset; // see RULE_05
    end else if (mask_wr) begin
      event_report_mask <= mask_wdata; // see RULE_04
    end
  end

  // one report per cycle: system status first, then lowest event number
  always_comb begin
    next_valid = 1'b0;
    next_code = event_filter_pkg::code_base;
    served = 16'h0000;
    serve_unack = 1'b0;
    serve_ovf = 1'b0;
    next_time = 32'h0000_0000;
    if (unack_pend) begin
      next_valid = 1'b1;
      next_code = event_filter_pkg::code_unack_reset;
      next_time = unack_stamp;
      serve_unack = 1'b1;
    end else if (ovf_pend) begin
      next_valid = 1'b1;
      next_code = event_filter_pkg::code_overflow;
      next_time = ovf_stamp;
      serve_ovf = 1'b1;
    end else begin
      for (int i = event_filter_pkg::num_events - 1; i >= 0; i--) begin
        if (pending[i]) begin
          next_valid = 1'b1;
          next_code = 5'(i + 1);
          next_time = stamp[i];
          served = 16'h0001 << i;
        end
      end
    end
    // new arrivals win over the service clear
    next_pending = (pending & ~served) | masked;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pending <= 16'h0000;
    end else begin
      pending <= next_pending;
    end
  end

  // status words bypass the mask; set wins over the service clear
  assign next_unack = (unack_pend & ~serve_unack) | unack_reset; // see RULE_12 see RULE_06
  assign next_ovf = (ovf_pend & ~serve_ovf) | event_overflow; // see RULE_12

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      unack_pend <= 1'b0;
    end else begin
      unack_pend <= next_unack;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ovf_pend <= 1'b0;
    end else begin
      ovf_pend <= next_ovf;
    end
  end

  // status stamps follow the same open-slot rule as event stamps
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      unack_stamp <= 32'h0000_0000;
    end else if (unack_reset && (!unack_pend || serve_unack)) begin
      unack_stamp <= time_now; // see RULE_13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ovf_stamp <= 32'h0000_0000;
    end else if (event_overflow && (!ovf_pend || serve_ovf)) begin
      ovf_stamp <= time_now; // see RULE_13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      report_valid <= 1'b0;
    end else begin
      report_valid <= next_valid;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      report_code <= event_filter_pkg::code_base;
    end else begin
      report_code <= next_code;
    end
  end

  // time of detection, not of report, so queued events keep their time
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      report_time <= 32'h0000_0000;
    end else begin
      report_time <= next_time; // see RULE_13
    end
  end
endmodule
`default_nettype wire

/* File: event_filter_pkg.sv */
// constants for the trigger event report filter
// assumes a single 100 MHz system clock domain
package event_filter_pkg;
  localparam int unsigned num_events = 16;
  localparam logic [15:0] mask_reset = 16'hffff;
  localparam logic [4:0] code_unack_reset = 5'h01;
  localparam logic [4:0] code_overflow = 5'h02;
  localparam int unsigned pos_overcurrent = 0;
  localparam int unsigned pos_residual_volt = 1;
  localparam int unsigned pos_neutral_curr = 2;
  localparam int unsigned pos_overvoltage = 3;
  localparam int unsigned pos_undervoltage = 4;
  localparam int unsigned pos_binary_first = 5;
  localparam int unsigned pos_manual_ext = 13;
  localparam int unsigned pos_remote = 14;
  localparam int unsigned pos_periodic = 15;
  localparam logic [4:0] code_base = 5'h00;
endpackage

/* File: pin_sync.sv */
// three-stage input synchroniser with agreement of last two stages
// assumes asynchronous pins sampled on clk_sys
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      level <= 1'b0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule
`default_nettype wire

/* File: filter_monitor.sv */
// concurrent checks on the trigger event report filter ports
// assumes one clk_sys domain with sync active-low nrst
`timescale 1ns/100ps
`default_nettype none
module filter_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic mask_wr,
  input wire logic [15:0] mask_wdata,
  input wire logic [15:0] event_report_mask,
  input wire logic trig_overcurrent,
  input wire logic [7:0] trig_binary_change,
  input wire logic unack_reset,
  input wire logic event_overflow,
  input wire logic [31:0] time_now,
  input wire logic report_valid,
  input wire logic [4:0] report_code,
  input wire logic [31:0] report_time,
  input wire logic [15:0] pending
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  mask_write_a: assert property (mask_wr |=> event_report_mask == $past(mask_wdata))
    else $error("mask write lost");
  mask_hold_a: assert property (!mask_wr |=> $stable(event_report_mask))
    else $error("mask moved");
  mask_reset_a: assert property (disable iff (1'b0) !nrst |=> event_report_mask == 16'hffff)
    else $error("mask reset value");
  status_first_a: assert property (unack_reset |-> ##[1:3] (report_valid && report_code == 5'h01))
    else $error("status report missing");
  pend_cause_a: assert property ($rose(pending[0]) |-> $past(trig_overcurrent && event_report_mask[0]))
    else $error("pending without cause");
  bin_pend_a: assert property (trig_binary_change[0] && event_report_mask[5] |=> pending[5])
    else $error("binary event lost");
  code_range_a: assert property (report_valid |-> report_code inside {[5'h01:5'h10]})
    else $error("bad report code");
  stamp_a: assert property (trig_overcurrent && event_report_mask[0] && !pending[0]
    && !unack_reset && !event_overflow && !$past(unack_reset)
    |-> ##2 (report_valid && report_code == 5'h01 && report_time == $past(time_now, 2)))
    else $error("bad time stamp");
endmodule
bind trigger_event_report_filter filter_monitor u_mon (.*);
`default_nettype wire

/* File: mask_host.sv */
// host model: writes the report mask
// assumes the filter takes mask_wr on rising clk_sys
`timescale 1ns/100ps
`default_nettype none
module mask_host (
  input wire logic clk_sys,
  output logic mask_wr,
  output logic [15:0] mask_wdata
);
  initial begin
    mask_wr = 1'b0;
    mask_wdata = 16'h0000;
  end
  // sum of weights, any 16-bit value; link events stay on the host side
  task automatic put(input logic [15:0] v);
    @(negedge clk_sys);
    mask_wr = 1'b1;
    mask_wdata = v;
    @(negedge clk_sys);
    mask_wr = 1'b0;
    mask_wdata = ~v;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the trigger event report filter
// assumes mask_host as writer and filter_monitor bound in
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0, nrst = 1'b0, external_trigger_pin = 1'b0;
  logic unack_reset = 1'b0, event_overflow = 1'b0;
  logic [15:0] trig = 16'h0000;
  logic [31:0] time_now = 32'h0000_0000;
  wire logic mask_wr, trig_overcurrent, trig_residual_volt, trig_neutral_curr;
  wire logic trig_overvoltage, trig_undervoltage, manual_trigger_pin;
  wire logic remote_trigger_command, periodic_trigger, report_valid;
  wire logic [7:0] trig_binary_change;
  wire logic [4:0] report_code;
  wire logic [15:0] mask_wdata, event_report_mask, pending;
  wire logic [31:0] report_time;
  int err_count = 0, checks_done = 0;
  assign {periodic_trigger, remote_trigger_command, manual_trigger_pin, trig_binary_change,
    trig_undervoltage, trig_overvoltage, trig_neutral_curr, trig_residual_volt,
    trig_overcurrent} = trig;
  trigger_event_report_filter u_dut (.*);
  mask_host u_host (.*);
  always #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) time_now <= time_now + 32'h0000_0001;
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic fire(input int idx, input int len);
    @(negedge clk_sys);
    trig[idx] = 1'b1;
    repeat (len) @(negedge clk_sys);
    trig[idx] = 1'b0;
  endtask
  // back: cycles between the detection edge and the report edge
  task automatic expect_report(input logic [4:0] code, input logic [31:0] back);
    int n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (report_valid !== 1'b1 && n < 30);
    check("code", report_code, code);
    check("stamp", report_time, time_now - back);
  endtask
  task automatic t_reset();
    check("mask", event_report_mask, 16'hffff);
    check("pending", pending, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_table();
    // one event at a time with only its own bit set; pin pulse outlasts sync
    for (int i = 0; i < 16; i++) begin
      u_host.put(16'h0001 << i);
      check("mask", event_report_mask, 16'h0001 << i);
      fire(i, (i == 13) ? 3 : 1);
      expect_report(5'(i + 1), 32'h0000_0001);
    end
    $display("event table test done");
  endtask
  task automatic t_late();
    u_host.put(16'hffff);
    fork
      fire(1, 1);
      u_host.put(16'h0000);
    join
    expect_report(5'h02, 32'h0000_0001);
    fire(1, 1);
    repeat (12) begin
      @(posedge clk_sys);
      #1 check("quiet", report_valid, 1'b0);
    end
    $display("late mask test done");
  endtask
  task automatic t_status();
    @(negedge clk_sys);
    {unack_reset, event_overflow} = 2'b11;
    @(negedge clk_sys);
    {unack_reset, event_overflow} = 2'b00;
    expect_report(5'h01, 32'h0000_0001);
    expect_report(5'h02, 32'h0000_0002);
    $display("status test done");
  endtask
  task automatic t_external();
    u_host.put(16'h2000);
    @(negedge clk_sys);
    external_trigger_pin = 1'b1;
    repeat (3) @(negedge clk_sys);
    external_trigger_pin = 1'b0;
    expect_report(5'h0e, 32'h0000_0001);
    $display("external pin test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    nrst = 1'b1;
    t_reset();
    t_table();
    t_late();
    t_status();
    t_external();
    tally_and_finish();
  end
  initial begin
    #50000;
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
